// file: pkg/smdc_defs.vh
// Constants for the serial modulation data capture block
// How it works
// R1: Data pin high is one, low zero
// R2: Source keeps bit rate at or below limit
// R3: Normal mode samples data on clock fall
// R4: Symbol mode samples data on strobe fall
// R5: Source starts each bit at clock rise
// R6: Data and strobe both sampled on clock fall
// R7: Clock and strobe stay at or below limit
// R8: Strobe may repeat or pulse only once
// R9: Source holds strobe high over first bit
// R10: Single or continuous strobe both accepted
// R11: Mode input picks normal or symbol clocking
`ifndef SMDC_DEFS_VH
`define SMDC_DEFS_VH

// ----------------------------------------------------------------
// Link limits and local clock
// ----------------------------------------------------------------
`define SMDC_MAX_BIT_RATE_MBPS  50
`define SMDC_MAX_LINK_CLK_MHZ   50
`define SMDC_CLK_PERIOD_NS      25
`define SMDC_CLK_MHZ            40

// ----------------------------------------------------------------
// Structure and reset values
// ----------------------------------------------------------------
`define SMDC_SYNC_STAGES        2
`define SMDC_CNT_W              8
`define SMDC_WORD_W             16
`define SMDC_MODE_NORMAL        1'b0
`define SMDC_MODE_SYMBOL        1'b1
`define SMDC_CNT_RESET          8'h00
`define SMDC_WORD_RESET         16'h0000

`endif

// file: core/smdc_sync.v
// Two-stage synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module smdc_sync (
  input  wire clk,
  input  wire reset,
  input  wire async_in,
  output reg  sync_out
);

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  reg meta;

  // First stage feeds only the second stage, nothing else looks at it
  always @(posedge clk) begin
    if (reset) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // smdc_sync

`default_nettype wire

// file: core/smdc_capture.v
// Serial data capture: data, data clock and symbol strobe into bits and symbols
`timescale 1ns/1ps
`default_nettype none
`include "smdc_defs.vh"

module smdc_capture #(
  parameter CNT_W  = `SMDC_CNT_W,
  parameter WORD_W = `SMDC_WORD_W
) (
  input  wire              clk,
  input  wire              reset,
  input  wire              serial_data,
  input  wire              data_clock,
  input  wire              symbol_strobe,
  input  wire              symbol_mode,
  input  wire [CNT_W-1:0]  symbol_len_m1,
  output reg               bit_valid,
  output reg               bit_data,
  output reg               bit_first,
  output reg               sym_valid,
  output reg  [WORD_W-1:0] sym_word,
  output reg               aligned
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // All three pins see the same two-stage delay, so the data and
  // strobe levels line up with the clock edge the block detects.
  // Limitation: the local clock must run well above twice the link
  // clock; at 40 MHz a link near its 50 MHz ceiling aliases.
  wire data_s;
  wire dclk_s;
  wire strobe_s;

  smdc_sync u_sync_data (
    .clk      (clk),
    .reset    (reset),
    .async_in (serial_data),
    .sync_out (data_s)
  );

  smdc_sync u_sync_dclk (
    .clk      (clk),
    .reset    (reset),
    .async_in (data_clock),
    .sync_out (dclk_s)
  );

  smdc_sync u_sync_strobe (
    .clk      (clk),
    .reset    (reset),
    .async_in (symbol_strobe),
    .sync_out (strobe_s)
  );

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  reg dclk_prev;
  reg strobe_prev;
  reg mode_prev;

  // Previous levels of the synchronised clocks, and the mode seen last
  always @(posedge clk) begin
    if (reset) begin
      dclk_prev   <= 1'b0;
      strobe_prev <= 1'b0;
      mode_prev   <= `SMDC_MODE_NORMAL;
    end else begin
      dclk_prev   <= dclk_s;
      strobe_prev <= strobe_s;
      mode_prev   <= symbol_mode;
    end
  end

  wire dclk_fall;
  wire strobe_fall;
  wire mode_change;
  wire use_symbol;
  wire take_bit;

  // Falling edges only; rising edges mark bit starts and are not used
  assign dclk_fall   = dclk_prev & ~dclk_s;                  // R3 R5
  assign strobe_fall = strobe_prev & ~strobe_s;              // R4
  assign use_symbol  = (symbol_mode == `SMDC_MODE_SYMBOL);   // R11
  assign mode_change = (symbol_mode != mode_prev);
  // Rates above half the local clock are not refused: each detected fall is a bit unless symbol_mode changes in that cycle
  assign take_bit    = use_symbol ? strobe_fall : dclk_fall; // R2 R7 R11

  // ----------------------------------------------------------------
  // Next-state logic for bit position and symbol assembly
  // ----------------------------------------------------------------
  reg [CNT_W-1:0]  bit_cnt;
  reg [WORD_W-1:0] shift;

  reg [CNT_W-1:0]  next_bit_cnt;
  reg [WORD_W-1:0] next_shift;
  reg              next_aligned;
  reg              next_first;
  reg              next_last;

  always @* begin
    next_bit_cnt = bit_cnt;
    next_shift   = shift;
    next_aligned = aligned;
    next_first   = 1'b0;
    next_last    = 1'b0;
    if (mode_change) begin
      // Old alignment means nothing under the other clocking
      next_aligned = 1'b0;
      next_bit_cnt = `SMDC_CNT_RESET;
      next_shift   = `SMDC_WORD_RESET;
    end else if (take_bit) begin
      // High on the pin is a one, low a zero
      next_shift = {shift[WORD_W-2:0], data_s};              // R1
      if (use_symbol) begin
        // Each strobe fall is its own one-bit symbol, so older bits
        // must not leak into the word
        next_shift   = {{(WORD_W-1){1'b0}}, data_s};         // R4
        next_aligned = 1'b1;                                 // R4
        next_first   = 1'b1;
        next_last    = 1'b1;
        next_bit_cnt = `SMDC_CNT_RESET;
      end else if (strobe_s) begin
        // Strobe high at the clock fall marks the first bit
        next_aligned = 1'b1;                                 // R6 R9
        next_first   = 1'b1;
        next_shift   = {{(WORD_W-1){1'b0}}, data_s};         // R1
        next_last    = (symbol_len_m1 == `SMDC_CNT_RESET);
        next_bit_cnt = next_last ? `SMDC_CNT_RESET : {{(CNT_W-1){1'b0}}, 1'b1};
      end else if (aligned) begin
        // A single pulse suffices: the counter keeps the boundaries
        next_first = (bit_cnt == `SMDC_CNT_RESET);           // R8 R10
        next_last  = (bit_cnt == symbol_len_m1);             // R8 R10
        if (next_first)
          next_shift = {{(WORD_W-1){1'b0}}, data_s};
        if (next_last)
          next_bit_cnt = `SMDC_CNT_RESET;
        else
          next_bit_cnt = bit_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered state
  // ----------------------------------------------------------------
  // Bits before the first strobe are still passed out, but no
  // symbol is formed until a boundary has been seen.
  always @(posedge clk) begin
    if (reset) begin
      bit_cnt <= `SMDC_CNT_RESET;
      shift   <= `SMDC_WORD_RESET;
      aligned <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      shift   <= next_shift;
      aligned <= next_aligned;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // One-cycle pulses; data and word hold until the next capture
  always @(posedge clk) begin
    if (reset) begin
      bit_valid <= 1'b0;
      bit_data  <= 1'b0;
      bit_first <= 1'b0;
      sym_valid <= 1'b0;
      sym_word  <= `SMDC_WORD_RESET;
    end else begin
      bit_valid <= take_bit & ~mode_change;
      bit_first <= next_first;
      sym_valid <= next_last;
      if (take_bit & ~mode_change)
        bit_data <= data_s;                                  // R1 R3 R4
      if (next_last)
        sym_word <= next_shift;
    end
  end

endmodule // smdc_capture

`default_nettype wire

// file: test/smdc_capture_assertions.sv
// Port checker for the serial capture block
`timescale 1ns/1ps
`default_nettype none
module smdc_capture_assertions #(parameter CNT_W = 8, parameter WORD_W = 16) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              serial_data,
  input wire logic              data_clock,
  input wire logic              symbol_strobe,
  input wire logic              symbol_mode,
  input wire logic [CNT_W-1:0]  symbol_len_m1,
  input wire logic              bit_valid,
  input wire logic              bit_data,
  input wire logic              bit_first,
  input wire logic              sym_valid,
  input wire logic [WORD_W-1:0] sym_word,
  input wire logic              aligned
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Raw link falls, seen by the checker without synchronisers
  sequence nfall; !symbol_mode && $fell(data_clock); endsequence
  sequence sfall; symbol_mode && $fell(symbol_strobe); endsequence
  lat_norm_a: assert property (nfall |-> ##[3:5] bit_valid)
    else $error("no bit after data clock fall");
  lat_sym_a: assert property (sfall |-> ##[3:5] bit_valid && sym_valid && bit_first)
    else $error("no symbol after strobe fall");
  first_mark_a: assert property (nfall ##0 symbol_strobe |-> ##[3:5] bit_first)
    else $error("strobe at fall not marked");
  data_pol_a: assert property (bit_valid |-> bit_data == $past(serial_data, 3))
    else $error("captured bit differs from pin");
  sym_word_a: assert property (sym_valid && symbol_mode |-> sym_word == WORD_W'(bit_data))
    else $error("symbol word wrong in symbol mode");
  pulse_one_a: assert property (bit_valid |=> !bit_valid)
    else $error("bit pulse too long");
  first_bit_a: assert property (bit_first |-> bit_valid && aligned)
    else $error("first mark without aligned bit");
  hold_bit_a: assert property (!bit_valid |-> $stable(bit_data))
    else $error("bit changed without capture");
  hold_word_a: assert property (!sym_valid |-> $stable(sym_word))
    else $error("word changed without symbol");
  mode_clear_a: assert property ($changed(symbol_mode) |-> ##[1:2] !aligned)
    else $error("mode change kept alignment");
endmodule // smdc_capture_assertions
bind smdc_capture smdc_capture_assertions #(.CNT_W(CNT_W), .WORD_W(WORD_W)) u_chk (
  .clk(clk), .reset(reset), .serial_data(serial_data), .data_clock(data_clock),
  .symbol_strobe(symbol_strobe), .symbol_mode(symbol_mode), .symbol_len_m1(symbol_len_m1),
  .bit_valid(bit_valid), .bit_data(bit_data), .bit_first(bit_first),
  .sym_valid(sym_valid), .sym_word(sym_word), .aligned(aligned));
`default_nettype wire

// file: test/smdc_src_model.sv
// Behavioural external serial source
`timescale 1ns/1ps
`default_nettype none
module smdc_src_model (
  output var logic serial_data,
  output var logic data_clock,
  output var logic symbol_strobe
);
  // Link clock idles high, so no fall occurs between frames
  initial begin
    serial_data = 1'b0;
    data_clock = 1'b1;
    symbol_strobe = 1'b0;
  end
  // One bit per 200 ns, far below the rate limit; odd offset keeps phase unrelated
  task send(input [15:0] w, input int n, input sm, input mk);
    int i;
    #7;
    for (i = n - 1; i >= 0; i--) begin
      serial_data = w[i];
      symbol_strobe = sm | (mk && i == n - 1);
      #100;
      if (sm) symbol_strobe = 1'b0;
      else data_clock = 1'b0;
      #100;
      data_clock = 1'b1;
    end
    serial_data = ~serial_data; // Stale data must not look valid
    symbol_strobe = sm;
  endtask
endmodule // smdc_src_model
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the serial capture block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, reset, symbol_mode;
  logic [7:0]  symbol_len_m1;
  logic [15:0] last_word;
  wire         serial_data, data_clock, symbol_strobe;
  wire         bit_valid, bit_data, bit_first, sym_valid, aligned;
  wire  [15:0] sym_word;
  int          bad_count, n_checks, cyc, n_bits, n_first, n_sym;
  smdc_src_model src (.serial_data(serial_data), .data_clock(data_clock),
    .symbol_strobe(symbol_strobe));
  smdc_capture dut (.clk(clk), .reset(reset), .serial_data(serial_data),
    .data_clock(data_clock), .symbol_strobe(symbol_strobe), .symbol_mode(symbol_mode),
    .symbol_len_m1(symbol_len_m1), .bit_valid(bit_valid), .bit_data(bit_data),
    .bit_first(bit_first), .sym_valid(sym_valid), .sym_word(sym_word), .aligned(aligned));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Tally pulses; timeout ceiling is several times the expected run
  always @(posedge clk) begin
    cyc++;
    if (bit_valid === 1'b1) n_bits++;
    if (bit_first === 1'b1) n_first++;
    if (sym_valid === 1'b1) last_word = sym_word;
    if (sym_valid === 1'b1) n_sym++;
    if (cyc == 1500) begin
      bad_count++;
      conclude();
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Mode changes only while the link is idle
  task start(input m, input [7:0] len);
    @(posedge clk);
    symbol_mode <= m;
    symbol_len_m1 <= len;
    repeat (3) @(posedge clk);
    n_bits = 0;
    n_first = 0;
    n_sym = 0;
  endtask
  task t_single;
    start(1'b0, 8'h03);
    src.send(16'h003C, 8, 1'b0, 1'b1);
    repeat (6) @(posedge clk);
    chk(16'(n_bits), 16'h0008);
    chk(16'(n_sym), 16'h0002);
    chk(last_word, 16'h000C);
    chk({15'h0000, aligned}, 16'h0001);
    $display("single strobe test done");
  endtask
  task t_cont;
    start(1'b0, 8'h03);
    src.send(16'h0009, 4, 1'b0, 1'b1);
    src.send(16'h0006, 4, 1'b0, 1'b1);
    repeat (6) @(posedge clk);
    chk(16'(n_first), 16'h0002);
    chk(last_word, 16'h0006);
    $display("repeating strobe test done");
  endtask
  // One-bit symbols in normal mode: every bit is both first and last
  task t_len1;
    start(1'b0, 8'h00);
    src.send(16'h0005, 3, 1'b0, 1'b1);
    repeat (6) @(posedge clk);
    chk(16'(n_sym), 16'h0003);
    chk(16'(n_first), 16'h0003);
    chk(last_word, 16'h0001);
    chk({15'h0000, bit_data}, 16'h0001);
    $display("one-bit symbol test done");
  endtask
  task t_sym;
    start(1'b1, 8'h03);
    chk({15'h0000, aligned}, 16'h0000);
    src.send(16'h000B, 4, 1'b1, 1'b0);
    repeat (6) @(posedge clk);
    chk(16'(n_sym), 16'h0004);
    chk(last_word, 16'h0001);
    $display("symbol mode test done");
  endtask
  task t_nostrobe;
    start(1'b0, 8'h01);
    src.send(16'h0002, 2, 1'b0, 1'b0);
    repeat (6) @(posedge clk);
    chk(16'(n_bits), 16'h0002);
    chk(16'(n_sym), 16'h0000);
    $display("unmarked bits test done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    symbol_mode = 1'b0;
    symbol_len_m1 = 8'h00;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_single;
    t_cont;
    t_len1;
    t_sym;
    t_nostrobe;
    conclude;
  end
endmodule // testbench
`default_nettype wire
